/* File: logic/uirb_top.sv */
// UART interrupt, event input and two-entry receive buffer with APB register bank
// Assumes the shifters, baud generator and pulse coder sit outside and talk by pulses
//
// Contract
// R01: Infrared event accepted only when enable bit set
// R02: Receive vector on enabled data, start, sync error
// R03: Empty vector while buffer empty and enabled
// R04: Complete vector after frame out, buffer empty
// R05: Flags set regardless of interrupt enable
// R06: Request is enable AND flag, held
// R07: Enable bits 7,6,5,4,2 of control A
// R08: Low byte read returns oldest, advances buffer
// R09: Two-deep buffer; high byte describes readable entry
// R10: Software reads high byte first, except low-first
// R11: High byte read-only, flags at fixed bits
// R12: Complete flag tracks unread data; disable flushes
// R13: Overflow when full, shifter full, new start
// R14: Frame error from first stop bit only
// R15: Parity error zero when checking off
// R16: Auto LIN mode reports identifier parity
// R17: Error flags meaningless in SPI master mode
// R18: Transmit-complete cleared by vector or write one
// R19: Empty flag set at reset, cleared by write
// R20: Start flag cleared by one; zero when disabled
// R21: Writing one clears sync flag, idles receiver
// R22: Flags set same cycle; request is a level
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/10ps
`include "uirb_consts.svh"
module uirb_top import uirb_pkg::*; #(
  parameter int RX_DEPTH = 2,
  parameter logic [1:0] LIN_AUTO_CODE = 2'h3,
  parameter logic [1:0] SPI_MASTER_CODE = 2'h3,
  parameter logic [2:0] LOW_FIRST_CODE = 3'h6
) (
  input wire logic MCLK_I,
  input wire logic RST_I,
  input wire logic CE_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [5:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic RX_CHAR_VALID_I,
  input wire logic [8:0] RX_DATA_I,
  input wire logic RX_STOP_BAD_I,
  input wire logic RX_PARITY_BAD_I,
  input wire logic RX_START_I,
  input wire logic RX_SHIFT_FULL_I,
  input wire logic RX_START_DET_I,
  input wire logic RX_SYNC_ERR_I,
  input wire logic TX_SHIFT_DONE_I,
  input wire logic TX_LOAD_I,
  input wire logic TXC_VECTOR_ACK_I,
  input wire logic IR_EVENT_I,
  output logic IR_EVENT_O,
  output logic [8:0] TX_DATA_O,
  output logic TX_DATA_VALID_O,
  output logic RX_ENABLE_O,
  output logic TX_ENABLE_O,
  output logic RX_IDLE_O,
  output logic RXC_IRQ_O,
  output logic DRE_IRQ_O,
  output logic TXC_IRQ_O
);
  localparam int AW = (RX_DEPTH > 1) ? $clog2(RX_DEPTH) : 1;
  localparam int EW = 11;
  localparam logic [AW:0] FULL_COUNT = (AW + 1)'(RX_DEPTH);

  uirb_apb_state_t apb_state_reg;
  logic [3:0] addr_idx_reg;
  uirb_byte_t irq_enable_control_reg;
  uirb_byte_t rx_tx_enable_control_reg;
  uirb_byte_t frame_format_control_reg;
  logic [15:0] baud_reg;
  uirb_byte_t dbg_reg;
  uirb_byte_t event_input_control_reg;
  uirb_byte_t txpl_reg;
  logic [6:0] rxpl_reg;
  uirb_byte_t txdl_reg;
  logic txdh_reg;
  logic transmit_complete_flag_reg;
  logic tx_empty_flag_reg;
  logic start_frame_flag_reg;
  logic inconsistent_sync_flag_reg;
  logic ovf_reg;
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW-1:0] rd_ptr_next;
  logic [AW:0] count_reg;
  logic [EW-1:0] head;
  logic [EW-1:0] head_vis;
  logic [EW-1:0] entry_in;
  logic [31:0] rd_word;
  logic setup;
  logic done;
  logic wr;
  logic rd;
  logic push;
  logic pop;
  logic receive_complete_flag;
  logic rxen;
  logic sfden;
  logic lin_auto;
  logic spi_master;
  logic parity_on;
  logic low_first;

  // Index is legal when it names a printed register
  function automatic logic idx_mapped(input logic [3:0] idx);
    idx_mapped = (idx <= `UIRB_IDX_BAUD) || (idx >= `UIRB_IDX_DBG && idx <= `UIRB_IDX_RXPL);
  endfunction : idx_mapped

  // Read or write strobe for one register index
  function automatic logic hit(input logic strobe, input logic [3:0] idx, input logic [3:0] want);
    hit = strobe && (idx == want);
  endfunction : hit

  // Mode decoding
  assign rxen = rx_tx_enable_control_reg[`UIRB_RXEN_BIT];
  assign sfden = rx_tx_enable_control_reg[`UIRB_SFDEN_BIT];
  assign lin_auto = (rx_tx_enable_control_reg[2:1] == LIN_AUTO_CODE);
  assign spi_master = (frame_format_control_reg[7:6] == SPI_MASTER_CODE);
  assign parity_on = (frame_format_control_reg[5:4] != 2'h0);
  assign low_first = (frame_format_control_reg[2:0] == LOW_FIRST_CODE);
  assign receive_complete_flag = (count_reg != '0); // R12
  // Empty buffer reads as zero, hiding stale or unwritten storage
  assign head_vis = receive_complete_flag ? head : '0; // R09 R11

  // Bus phases: setup captures, access completes
  assign setup = CE_I && (apb_state_reg == UIRB_IDLE) && PSEL_I && !PENABLE_I;
  assign done = CE_I && (apb_state_reg == UIRB_ACCESS) && PSEL_I && PENABLE_I;
  assign wr = done && PWRITE_I && !PSLVERR_O;
  assign rd = done && !PWRITE_I && !PSLVERR_O;

  // Buffer movement; in low-first nine-bit mode the later high byte read advances
  assign pop = receive_complete_flag && (low_first ? hit(rd, addr_idx_reg, `UIRB_IDX_RXDH)
                                   : hit(rd, addr_idx_reg, `UIRB_IDX_RXDL)); // R08 R10
  assign push = CE_I && rxen && RX_CHAR_VALID_I && (count_reg != FULL_COUNT); // R09
  assign rd_ptr_next = rxen ? (pop ? AW'(rd_ptr_reg + 1'b1) : rd_ptr_reg) : '0;
  assign entry_in = {RX_STOP_BAD_I, RX_PARITY_BAD_I & (parity_on | lin_auto), RX_DATA_I}; // R14 R15 R16

  // Bus slave state and answer
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      apb_state_reg <= UIRB_IDLE;
      addr_idx_reg <= 4'h0;
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
      PRDATA_O <= 32'h0000_0000;
    end else if (CE_I) begin
      unique case (apb_state_reg)
        UIRB_IDLE: begin
          if (setup) begin
            apb_state_reg <= UIRB_ACCESS;
            addr_idx_reg <= PADDR_I[5:2];
            PREADY_O <= 1'b1;
            PSLVERR_O <= !idx_mapped(PADDR_I[5:2]) || (PADDR_I[1:0] != 2'h0);
            PRDATA_O <= rd_word;
          end
        end
        UIRB_ACCESS: begin
          if (done) begin
            apb_state_reg <= UIRB_IDLE;
            PREADY_O <= 1'b0;
            PSLVERR_O <= 1'b0;
            PRDATA_O <= 32'h0000_0000;
          end
        end
      endcase
    end
  end

  // Read data for the addressed register
  always_comb begin
    rd_word = 32'h0000_0000;
    if (PADDR_I[1:0] == 2'h0) begin
      unique case (PADDR_I[5:2])
        `UIRB_IDX_RXDL: rd_word[7:0] = head_vis[7:0]; // R08
        `UIRB_IDX_RXDH: rd_word[7:0] = {receive_complete_flag, ovf_reg & !spi_master, 3'h0,
                                        head_vis[10] & !spi_master,
                                        head_vis[9] & (parity_on | lin_auto) & !spi_master,
                                        head_vis[8]}; // R11 R14 R15 R16 R17
        `UIRB_IDX_TXDL: rd_word[7:0] = txdl_reg;
        `UIRB_IDX_STATUS: rd_word[7:0] = {receive_complete_flag, transmit_complete_flag_reg, tx_empty_flag_reg, start_frame_flag_reg & sfden,
                                          inconsistent_sync_flag_reg, 3'h0}; // R05 R20
        `UIRB_IDX_IRQ_ENABLE_CONTROL: rd_word[7:0] = irq_enable_control_reg;
        `UIRB_IDX_RX_TX_ENABLE_CONTROL: rd_word[7:0] = rx_tx_enable_control_reg;
        `UIRB_IDX_FRAME_FORMAT_CONTROL: rd_word[7:0] = frame_format_control_reg;
        `UIRB_IDX_BAUD: rd_word[15:0] = baud_reg;
        `UIRB_IDX_DBG: rd_word[7:0] = dbg_reg;
        `UIRB_IDX_EVENT_INPUT_CONTROL: rd_word[7:0] = event_input_control_reg;
        `UIRB_IDX_TXPL: rd_word[7:0] = txpl_reg;
        `UIRB_IDX_RXPL: rd_word[6:0] = rxpl_reg;
        default: rd_word = 32'h0000_0000;
      endcase
    end
  end

  // Control registers written by software
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      irq_enable_control_reg <= `UIRB_RST_BYTE;
      rx_tx_enable_control_reg <= `UIRB_RST_BYTE;
      frame_format_control_reg <= `UIRB_RST_BYTE;
      baud_reg <= 16'h0000;
      dbg_reg <= `UIRB_RST_BYTE;
      event_input_control_reg <= `UIRB_RST_BYTE;
      txpl_reg <= `UIRB_RST_BYTE;
      rxpl_reg <= 7'h00;
    end else if (CE_I) begin
      if (hit(wr, addr_idx_reg, `UIRB_IDX_IRQ_ENABLE_CONTROL)) irq_enable_control_reg <= PWDATA_I[7:0]; // R07
      if (hit(wr, addr_idx_reg, `UIRB_IDX_RX_TX_ENABLE_CONTROL)) rx_tx_enable_control_reg <= PWDATA_I[7:0];
      if (hit(wr, addr_idx_reg, `UIRB_IDX_FRAME_FORMAT_CONTROL)) frame_format_control_reg <= PWDATA_I[7:0];
      if (hit(wr, addr_idx_reg, `UIRB_IDX_BAUD)) baud_reg <= PWDATA_I[15:0];
      if (hit(wr, addr_idx_reg, `UIRB_IDX_DBG)) dbg_reg <= {7'h00, PWDATA_I[0]};
      if (hit(wr, addr_idx_reg, `UIRB_IDX_EVENT_INPUT_CONTROL)) event_input_control_reg <= {7'h00, PWDATA_I[0]};
      if (hit(wr, addr_idx_reg, `UIRB_IDX_TXPL)) txpl_reg <= PWDATA_I[7:0];
      if (hit(wr, addr_idx_reg, `UIRB_IDX_RXPL)) rxpl_reg <= PWDATA_I[6:0];
    end
  end

  // Transmit buffer and its empty flag
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      txdl_reg <= `UIRB_RST_BYTE;
      txdh_reg <= 1'b0;
      tx_empty_flag_reg <= `UIRB_RST_TX_EMPTY_FLAG; // R19
    end else if (CE_I) begin
      if (hit(wr, addr_idx_reg, `UIRB_IDX_TXDH)) txdh_reg <= PWDATA_I[0];
      if (hit(wr, addr_idx_reg, `UIRB_IDX_TXDL) && tx_empty_flag_reg) begin
        txdl_reg <= PWDATA_I[7:0];
        tx_empty_flag_reg <= 1'b0; // R19
      end else if (TX_LOAD_I) begin
        tx_empty_flag_reg <= 1'b1; // R03 R22
      end
    end
  end

  // Hardware-set status flags; a set beats a clear in the same cycle
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      transmit_complete_flag_reg <= 1'b0;
      start_frame_flag_reg <= 1'b0;
      inconsistent_sync_flag_reg <= 1'b0;
      ovf_reg <= 1'b0;
    end else if (CE_I) begin
      if (TX_SHIFT_DONE_I && tx_empty_flag_reg) transmit_complete_flag_reg <= 1'b1; // R04 R05 R22
      else if (TXC_VECTOR_ACK_I || (hit(wr, addr_idx_reg, `UIRB_IDX_STATUS)
               && PWDATA_I[`UIRB_TRANSMIT_COMPLETE_FLAG_BIT])) transmit_complete_flag_reg <= 1'b0; // R18
      if (RX_START_DET_I && sfden) start_frame_flag_reg <= 1'b1; // R05 R20
      else if (hit(wr, addr_idx_reg, `UIRB_IDX_STATUS) && PWDATA_I[`UIRB_START_FRAME_FLAG_BIT])
        start_frame_flag_reg <= 1'b0; // R20
      if (RX_SYNC_ERR_I) inconsistent_sync_flag_reg <= 1'b1; // R05
      else if (hit(wr, addr_idx_reg, `UIRB_IDX_STATUS) && PWDATA_I[`UIRB_INCONSISTENT_SYNC_FLAG_BIT])
        inconsistent_sync_flag_reg <= 1'b0; // R21
      if (count_reg == FULL_COUNT && RX_SHIFT_FULL_I && RX_START_I) ovf_reg <= 1'b1; // R13
      else if (hit(rd, addr_idx_reg, `UIRB_IDX_RXDL) || !rxen) ovf_reg <= 1'b0; // R13
    end
  end

  // Receive buffer pointers and fill level; disabling the receiver flushes
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else if (CE_I) begin
      rd_ptr_reg <= rd_ptr_next;
      if (!rxen) begin
        wr_ptr_reg <= '0;
        count_reg <= '0; // R12
      end else begin
        if (push) wr_ptr_reg <= AW'(wr_ptr_reg + 1'b1);
        if (push && !pop) count_reg <= count_reg + 1'b1; // R09
        else if (pop && !push) count_reg <= count_reg - 1'b1; // R08
      end
    end
  end

  // Entry storage, read ahead at the next head so flags follow each read
  uirb_rx_mem #(
    .WIDTH(EW),
    .DEPTH(RX_DEPTH),
    .AW(AW)
  ) u_rx_mem (
    .clk_i(MCLK_I),
    .rst_i(RST_I),
    .ce_i(CE_I),
    .we_i(push),
    .waddr_i(wr_ptr_reg),
    .wdata_i(entry_in),
    .raddr_i(rd_ptr_next),
    .rdata_o(head)
  ); // R09

  // Registered outputs toward the shifters and event system
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      IR_EVENT_O <= 1'b0;
      TX_DATA_O <= 9'h000;
      TX_DATA_VALID_O <= 1'b0;
      RX_ENABLE_O <= 1'b0;
      TX_ENABLE_O <= 1'b0;
      RX_IDLE_O <= 1'b0;
    end else if (CE_I) begin
      IR_EVENT_O <= IR_EVENT_I && event_input_control_reg[`UIRB_INFRARED_EVENT_INPUT_ENABLE_BIT]; // R01
      TX_DATA_O <= {txdh_reg, txdl_reg};
      TX_DATA_VALID_O <= !tx_empty_flag_reg;
      RX_ENABLE_O <= rxen;
      TX_ENABLE_O <= rx_tx_enable_control_reg[`UIRB_TXEN_BIT];
      RX_IDLE_O <= hit(wr, addr_idx_reg, `UIRB_IDX_STATUS) && PWDATA_I[`UIRB_INCONSISTENT_SYNC_FLAG_BIT]; // R21
    end
  end

  // Interrupt vectors
  uirb_irq_gate u_irq_gate (
    .clk_i(MCLK_I),
    .rst_i(RST_I),
    .ce_i(CE_I),
    .rxc_flag_i(receive_complete_flag),
    .start_flag_i(start_frame_flag_reg & sfden),
    .sync_flag_i(inconsistent_sync_flag_reg),
    .dre_flag_i(tx_empty_flag_reg),
    .txc_flag_i(transmit_complete_flag_reg),
    .enable_i(irq_enable_control_reg),
    .rxc_irq_o(RXC_IRQ_O),
    .dre_irq_o(DRE_IRQ_O),
    .txc_irq_o(TXC_IRQ_O)
  ); // R22

  // Checks
  ir_gate_a: assert property (@(posedge MCLK_I) disable iff (RST_I) // R01
    CE_I |=> IR_EVENT_O == $past(IR_EVENT_I && event_input_control_reg[0])) else $error("ir gate wrong");
  rxc_vector_a: assert property (@(posedge MCLK_I) disable iff (RST_I) // R02
    (CE_I && receive_complete_flag && irq_enable_control_reg[7]) |=> RXC_IRQ_O) else $error("rx vector missing");
  dre_vector_a: assert property (@(posedge MCLK_I) disable iff (RST_I) // R03
    (CE_I && tx_empty_flag_reg && irq_enable_control_reg[5]) |=> DRE_IRQ_O) else $error("empty vector missing");
  txc_drop_a: assert property (@(posedge MCLK_I) disable iff (RST_I) // R06
    (CE_I && (!transmit_complete_flag_reg || !irq_enable_control_reg[6])) |=> !TXC_IRQ_O) else $error("tx vector stuck");
  txc_set_a: assert property (@(posedge MCLK_I) disable iff (RST_I) // R05
    (CE_I && TX_SHIFT_DONE_I && tx_empty_flag_reg) |=> transmit_complete_flag_reg) else $error("tx flag not set");
  pop_step_a: assert property (@(posedge MCLK_I) disable iff (RST_I) // R08
    (pop && !push && rxen) |=> count_reg == $past(count_reg) - 1'b1) else $error("pop lost");
  fifo_depth_a: assert property (@(posedge MCLK_I) disable iff (RST_I) // R09
    count_reg <= FULL_COUNT) else $error("buffer too deep");
  flush_rx_a: assert property (@(posedge MCLK_I) disable iff (RST_I) // R12
    (CE_I && !rxen) |=> (count_reg == '0) && !receive_complete_flag) else $error("flush failed");
  ovf_set_a: assert property (@(posedge MCLK_I) disable iff (RST_I) // R13
    (CE_I && rxen && count_reg == FULL_COUNT && RX_SHIFT_FULL_I && RX_START_I) |=> ovf_reg)
    else $error("overflow not set");
  parity_error_flag_off_a: assert property (@(posedge MCLK_I) disable iff (RST_I) // R15
    (PREADY_O && addr_idx_reg == `UIRB_IDX_RXDH && $past(!parity_on && !lin_auto))
    |-> !PRDATA_O[1]) else $error("parity shown while off");
  dre_clear_a: assert property (@(posedge MCLK_I) disable iff (RST_I) // R19
    (hit(wr, addr_idx_reg, `UIRB_IDX_TXDL) && tx_empty_flag_reg) |=> !tx_empty_flag_reg ##1 TX_DATA_VALID_O)
    else $error("empty flag not cleared");
  isf_clear_a: assert property (@(posedge MCLK_I) disable iff (RST_I) // R21
    (hit(wr, addr_idx_reg, `UIRB_IDX_STATUS) && PWDATA_I[3] && !RX_SYNC_ERR_I)
    |=> !inconsistent_sync_flag_reg && RX_IDLE_O) else $error("sync flag not cleared");
endmodule : uirb_top

/* File: logic/uirb_consts.svh */
// Register indices, field positions, reset values of the UART irq/rx-buffer block
// Assumes inclusion by bare name; the byte address of a register is four times its index
`ifndef UIRB_CONSTS_SVH
`define UIRB_CONSTS_SVH
// Register indices
`define UIRB_IDX_RXDL 4'h0
`define UIRB_IDX_RXDH 4'h1
`define UIRB_IDX_TXDL 4'h2
`define UIRB_IDX_TXDH 4'h3
`define UIRB_IDX_STATUS 4'h4
`define UIRB_IDX_IRQ_ENABLE_CONTROL 4'h5
`define UIRB_IDX_RX_TX_ENABLE_CONTROL 4'h6
`define UIRB_IDX_FRAME_FORMAT_CONTROL 4'h7
`define UIRB_IDX_BAUD 4'h8
`define UIRB_IDX_DBG 4'hb
`define UIRB_IDX_EVENT_INPUT_CONTROL 4'hc
`define UIRB_IDX_TXPL 4'hd
`define UIRB_IDX_RXPL 4'he
// Interrupt enable bits
`define UIRB_RECEIVE_COMPLETE_IRQ_ENABLE_BIT 7
`define UIRB_TRANSMIT_COMPLETE_IRQ_ENABLE_BIT 6
`define UIRB_TX_EMPTY_IRQ_ENABLE_BIT 5
`define UIRB_START_FRAME_IRQ_ENABLE_BIT 4
`define UIRB_AUTOBAUD_ERROR_IRQ_ENABLE_BIT 2
// Status and receive high byte bits
`define UIRB_RECEIVE_COMPLETE_FLAG_BIT 7
`define UIRB_TRANSMIT_COMPLETE_FLAG_BIT 6
`define UIRB_TX_EMPTY_FLAG_BIT 5
`define UIRB_START_FRAME_FLAG_BIT 4
`define UIRB_INCONSISTENT_SYNC_FLAG_BIT 3
`define UIRB_OVF_BIT 6
`define UIRB_FRAME_ERROR_FLAG_BIT 2
`define UIRB_PARITY_ERROR_FLAG_BIT 1
// Control fields
`define UIRB_RXEN_BIT 7
`define UIRB_TXEN_BIT 6
`define UIRB_SFDEN_BIT 4
`define UIRB_INFRARED_EVENT_INPUT_ENABLE_BIT 0
// Reset values
`define UIRB_RST_BYTE 8'h00
`define UIRB_RST_TX_EMPTY_FLAG 1'b1
`endif

/* File: logic/uirb_pkg.sv */
// Types shared by the UART irq/rx-buffer block
// Assumes nothing of its surroundings
package uirb_pkg;
  typedef enum logic {UIRB_IDLE, UIRB_ACCESS} uirb_apb_state_t;
  typedef logic [7:0] uirb_byte_t;
endpackage : uirb_pkg

/* File: logic/uirb_rx_mem.sv */
// Small receive buffer storage with registered read data
// Assumes one writer; a write to the address being read is passed straight through
`timescale 1ns/10ps
module uirb_rx_mem #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 2,
  parameter int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [WIDTH-1:0] wdata_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [WIDTH-1:0] rdata_o
);
  logic [WIDTH-1:0] mem_reg [DEPTH];

  // Storage write
  always_ff @(posedge clk_i) begin
    if (ce_i && we_i) begin
      mem_reg[waddr_i] <= wdata_i;
    end
  end

  // Registered read with write bypass
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= '0;
    end else if (ce_i) begin
      if (we_i && (waddr_i == raddr_i)) begin
        rdata_o <= wdata_i;
      end else begin
        rdata_o <= mem_reg[raddr_i];
      end
    end
  end
endmodule : uirb_rx_mem

/* File: logic/uirb_irq_gate.sv */
// Combines flags with enables into three level interrupt requests
// Assumes flags and enables are registers of the same clock domain
`timescale 1ns/10ps
module uirb_irq_gate (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic rxc_flag_i,
  input wire logic start_flag_i,
  input wire logic sync_flag_i,
  input wire logic dre_flag_i,
  input wire logic txc_flag_i,
  input wire logic [7:0] enable_i,
  output logic rxc_irq_o,
  output logic dre_irq_o,
  output logic txc_irq_o
);
  // Registered AND of flag and enable, held as long as the flag stands
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rxc_irq_o <= 1'b0;
      dre_irq_o <= 1'b0;
      txc_irq_o <= 1'b0;
    end else if (ce_i) begin
      rxc_irq_o <= (rxc_flag_i & enable_i[`UIRB_RECEIVE_COMPLETE_IRQ_ENABLE_BIT]) |
                   (start_flag_i & enable_i[`UIRB_START_FRAME_IRQ_ENABLE_BIT]) |
                   (sync_flag_i & enable_i[`UIRB_AUTOBAUD_ERROR_IRQ_ENABLE_BIT]); // R02 R06
      dre_irq_o <= dre_flag_i & enable_i[`UIRB_TX_EMPTY_IRQ_ENABLE_BIT]; // R03 R06
      txc_irq_o <= txc_flag_i & enable_i[`UIRB_TRANSMIT_COMPLETE_IRQ_ENABLE_BIT]; // R04 R06
    end
  end
endmodule : uirb_irq_gate

/* File: sim/uirb_far_node.sv */
// Far-side model: receiver and transmitter shifter pulses into the block
// Assumes the bench calls its tasks from one sequence on the block clock
`timescale 1ns/10ps
module uirb_far_node (
  input wire logic clk_i,
  output logic char_valid_o,
  output logic [8:0] data_o,
  output logic stop_bad_o,
  output logic parity_bad_o,
  output logic shift_full_o,
  output logic [5:0] ev_o
);
  // Idle levels; data lines carry a pattern, not a stale character
  initial begin
    char_valid_o = 1'b0;
    data_o = 9'h155;
    stop_bad_o = 1'b0;
    parity_bad_o = 1'b0;
    shift_full_o = 1'b0;
    ev_o = 6'h00;
  end
  // One character with its stop and parity status, valid one cycle
  task automatic send(input logic [8:0] d, input logic sb, input logic pb);
    @(posedge clk_i);
    char_valid_o <= 1'b1;
    data_o <= d;
    stop_bad_o <= sb;
    parity_bad_o <= pb;
    @(posedge clk_i);
    char_valid_o <= 1'b0;
    data_o <= ~d;
    stop_bad_o <= ~sb;
    parity_bad_o <= ~pb;
  endtask : send
  // One-cycle event pulses: start, detect, sync, done, load, vector
  task automatic pulse(input logic [5:0] sel);
    @(posedge clk_i);
    ev_o <= sel;
    @(posedge clk_i);
    ev_o <= 6'h00;
  endtask : pulse
  // Shifter holds a waiting character
  task automatic full(input logic f);
    @(posedge clk_i);
    shift_full_o <= f;
  endtask : full
endmodule : uirb_far_node

/* File: sim/test_uart_irq_and_receive_buffer.sv */
// Self-checking bench: register bus, flags, vectors and receive buffer
// Assumes the header, package and design files are compiled before it
`timescale 1ns/10ps
`include "uirb_consts.svh"
module test_uart_irq_and_receive_buffer;
  logic mclk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, ir_ev = 1'b0;
  logic ce = 1'b1, idle_seen = 1'b0;
  logic [5:0] paddr = 6'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, ir_out, txv, rxen, txen, rxidle, i_rxc, i_dre, i_txc, er;
  wire cv, sb, pb, sf;
  logic [8:0] txd;
  wire [8:0] rd9;
  wire [5:0] ev;
  logic [7:0] rv;
  int error_cnt = 0;
  int tests_run = 0;
  // Clock, 8 ns period
  always #4 mclk = ~mclk;
  // Catch the one-cycle receiver idle pulse
  always @(posedge mclk) if (rxidle) idle_seen <= 1'b1;
  uirb_top dut_u (.MCLK_I(mclk), .RST_I(rst), .CE_I(ce), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .RX_CHAR_VALID_I(cv), .RX_DATA_I(rd9),
    .RX_STOP_BAD_I(sb), .RX_PARITY_BAD_I(pb), .RX_START_I(ev[0]), .RX_SHIFT_FULL_I(sf),
    .RX_START_DET_I(ev[1]), .RX_SYNC_ERR_I(ev[2]), .TX_SHIFT_DONE_I(ev[3]),
    .TX_LOAD_I(ev[4]), .TXC_VECTOR_ACK_I(ev[5]), .IR_EVENT_I(ir_ev), .IR_EVENT_O(ir_out),
    .TX_DATA_O(txd), .TX_DATA_VALID_O(txv), .RX_ENABLE_O(rxen), .TX_ENABLE_O(txen),
    .RX_IDLE_O(rxidle), .RXC_IRQ_O(i_rxc), .DRE_IRQ_O(i_dre), .TXC_IRQ_O(i_txc));
  uirb_far_node far_u (.clk_i(mclk), .char_valid_o(cv), .data_o(rd9), .stop_bad_o(sb),
    .parity_bad_o(pb), .shift_full_o(sf), .ev_o(ev));
  // Verdict and end of run
  task automatic results;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results
  // Compare seen with expected
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  // One APB transfer: setup, access held until ready is sampled
  task automatic apb(input logic wr, input logic [3:0] idx, input logic [7:0] wd);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, wd};
    @(posedge mclk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rv = prdata[7:0];
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (pready !== 1'b1) begin
      error_cnt++;
      $display("ERROR %0t: bus answer timed out", $time);
      results();
    end
  endtask : apb
  task automatic rdc(input logic [3:0] idx, input logic [7:0] exp, input string what);
    apb(1'b0, idx, 8'h00);
    chk({7'h00, er, rv}, {8'h00, exp}, what);
  endtask : rdc
  // Interrupt levels settle two cycles after their cause
  task automatic irqc(input logic [2:0] exp, input string what);
    repeat (2) @(posedge mclk);
    #1;
    chk({i_rxc, i_dre, i_txc}, exp, what);
  endtask : irqc
  // Main sequence
  initial begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    rdc(`UIRB_IDX_STATUS, 8'h20, "status reset");
    rdc(`UIRB_IDX_RXDH, 8'h00, "rx high reset");
    rdc(`UIRB_IDX_IRQ_ENABLE_CONTROL, 8'h00, "enables reset");
    apb(1'b0, 4'h9, 8'h00);
    chk({er, rv}, 9'h100, "unmapped read");
    apb(1'b1, `UIRB_IDX_IRQ_ENABLE_CONTROL, 8'hf4);
    rdc(`UIRB_IDX_IRQ_ENABLE_CONTROL, 8'hf4, "enables readback");
    apb(1'b1, `UIRB_IDX_RX_TX_ENABLE_CONTROL, 8'hc0);
    irqc(3'b010, "empty vector");
    chk({rxen, txen}, 2'b11, "enable copies");
    $display("test reset done");
    apb(1'b1, `UIRB_IDX_TXDL, 8'h5a);
    irqc(3'b000, "empty cleared");
    chk({txv, txd}, 10'h25a, "tx data");
    far_u.pulse(6'h10);
    far_u.pulse(6'h08);
    rdc(`UIRB_IDX_STATUS, 8'h60, "tx done flag");
    irqc(3'b011, "tx done vector");
    apb(1'b1, `UIRB_IDX_STATUS, 8'h40);
    irqc(3'b010, "tx done write clear");
    far_u.pulse(6'h08);
    far_u.pulse(6'h20);
    rdc(`UIRB_IDX_STATUS, 8'h20, "tx done vector clear");
    $display("test transmit done");
    apb(1'b1, `UIRB_IDX_FRAME_FORMAT_CONTROL, 8'h20);
    far_u.send(9'h1a5, 1'b1, 1'b0);
    rdc(`UIRB_IDX_STATUS, 8'ha0, "rx flag");
    irqc(3'b110, "rx vector");
    far_u.send(9'h03c, 1'b0, 1'b1);
    far_u.full(1'b1);
    far_u.pulse(6'h01);
    far_u.full(1'b0);
    rdc(`UIRB_IDX_RXDH, 8'hc5, "first high");
    rdc(`UIRB_IDX_RXDL, 8'ha5, "first low");
    rdc(`UIRB_IDX_RXDH, 8'h82, "second high");
    rdc(`UIRB_IDX_RXDL, 8'h3c, "second low");
    rdc(`UIRB_IDX_RXDH, 8'h00, "buffer empty");
    irqc(3'b010, "rx vector gone");
    $display("test receive done");
    apb(1'b1, `UIRB_IDX_IRQ_ENABLE_CONTROL, 8'h00);
    far_u.pulse(6'h02);
    rdc(`UIRB_IDX_STATUS, 8'h20, "start off");
    apb(1'b1, `UIRB_IDX_RX_TX_ENABLE_CONTROL, 8'hd0);
    far_u.pulse(6'h02);
    far_u.pulse(6'h04);
    rdc(`UIRB_IDX_STATUS, 8'h38, "flags unmasked");
    irqc(3'b000, "all masked");
    apb(1'b1, `UIRB_IDX_IRQ_ENABLE_CONTROL, 8'h10);
    irqc(3'b100, "start vector");
    apb(1'b1, `UIRB_IDX_STATUS, 8'h10);
    irqc(3'b000, "start cleared");
    chk({15'h0000, idle_seen}, 16'h0000, "receiver not idled");
    apb(1'b1, `UIRB_IDX_IRQ_ENABLE_CONTROL, 8'h04);
    irqc(3'b100, "sync vector");
    apb(1'b1, `UIRB_IDX_STATUS, 8'h08);
    rdc(`UIRB_IDX_STATUS, 8'h20, "sync cleared");
    chk({15'h0000, idle_seen}, 16'h0001, "receiver idled");
    irqc(3'b000, "sync vector gone");
    $display("test start and sync done");
    apb(1'b1, `UIRB_IDX_FRAME_FORMAT_CONTROL, 8'h00);
    far_u.send(9'h011, 1'b0, 1'b1);
    rdc(`UIRB_IDX_RXDH, 8'h80, "parity off");
    apb(1'b1, `UIRB_IDX_RX_TX_ENABLE_CONTROL, 8'h40);
    rdc(`UIRB_IDX_STATUS, 8'h20, "flush flag");
    rdc(`UIRB_IDX_RXDH, 8'h00, "flush high");
    @(posedge mclk);
    ir_ev <= 1'b1;
    irqc(3'b000, "no vectors");
    chk({15'h0000, ir_out}, 16'h0000, "event blocked");
    apb(1'b1, `UIRB_IDX_EVENT_INPUT_CONTROL, 8'h01);
    irqc(3'b000, "no vectors");
    chk({15'h0000, ir_out}, 16'h0001, "event passed");
    $display("test flush and event done");
    apb(1'b1, `UIRB_IDX_RX_TX_ENABLE_CONTROL, 8'hc6);
    apb(1'b1, `UIRB_IDX_FRAME_FORMAT_CONTROL, 8'h06);
    far_u.send(9'h0aa, 1'b0, 1'b1);
    rdc(`UIRB_IDX_RXDL, 8'haa, "low first data");
    rdc(`UIRB_IDX_RXDH, 8'h82, "identifier parity");
    rdc(`UIRB_IDX_RXDH, 8'h00, "low first popped");
    apb(1'b1, `UIRB_IDX_FRAME_FORMAT_CONTROL, 8'hc0);
    far_u.send(9'h1ff, 1'b1, 1'b1);
    rdc(`UIRB_IDX_RXDH, 8'h81, "master mode flags");
    rdc(`UIRB_IDX_RXDL, 8'hff, "master mode data");
    $display("test modes done");
    @(posedge mclk);
    ce <= 1'b0;
    ir_ev <= 1'b0;
    far_u.pulse(6'h08);
    irqc(3'b000, "frozen vectors");
    chk({15'h0000, ir_out}, 16'h0001, "frozen event");
    @(posedge mclk);
    ce <= 1'b1;
    rdc(`UIRB_IDX_STATUS, 8'h20, "frozen flag");
    chk({15'h0000, ir_out}, 16'h0000, "event released");
    $display("test clock enable done");
    results();
  end
endmodule : test_uart_irq_and_receive_buffer
